// ===== design/bdc_drive_ctrl.sv
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: Direction low runs reverse, open or high runs forward.
// R2: Run input low halts the motor, high runs it.
// R3: Halt brakes dynamically if stop method low, else coasts.
// R4: Outside party settles the stop method before commanding a halt.
// R5: Unconnected inputs read high: forward, run and coast.
// R6: Fault output low when normal, high once any alarm tripped.
// R7: Speed pulse toggles per hall edge: three periods per pole pair.
// R8: Target speed taken from the digitised setpoint value.
// R9: Setpoint below half a volt halts like the run input.
// R10: Any alarm drops drive power to coast and starts LED blinking.
// R11: Alarm latched, inputs ignored, cleared only by power cycle reset.
// R12: Blink count names alarm: one over-current, two overload, six reserved.
// R13: Missing or invalid hall pattern raises the three-blink alarm.
// R14: Supply over the upper limit raises the four-blink alarm.
// R15: Supply under the lower limit raises the five-blink alarm.
// R16: No hall movement after a run command raises seven-blink alarm.
// R17: Only the first alarm is shown; groups separated by a pause.
// R18: Each digital input synchronised and debounced, length by parameter.
module bdc_drive_ctrl #(
   parameter int DEB_CYC = bdc_pkg::DEBOUNCE_CYC,
   parameter int ON_CYC = bdc_pkg::BLINK_ON_CYC,
   parameter int OFF_CYC = bdc_pkg::BLINK_OFF_CYC,
   parameter int GAP_CYC = bdc_pkg::GROUP_PAUSE_CYC,
   parameter int START_CYC = bdc_pkg::STARTUP_CYC
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Control connector pins
   input wire logic direction_select_in,
   input wire logic run_in,
   input wire logic stop_method_in,
   input wire logic [9:0] speed_setpoint_in,
   // Protection sense pins
   input wire logic over_current_in,
   input wire logic overload_in,
   input wire logic over_voltage_in,
   input wire logic under_voltage_in,
   input wire logic [2:0] hall_in,
   // Register port
   input wire logic [3:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   output logic irq_out,
   // Power stage commands
   output logic motor_enable_out,
   output logic direction_out,
   output logic brake_out,
   output logic [9:0] target_speed_out,
   // Status outputs
   output logic fault_output_out,
   output logic speed_pulse_output_out,
   output logic fault_indicator_led_out,
   output logic power_indicator_led_out
);
   // ----------------------------------------
   // Input synchronisers and debounce
   // ----------------------------------------
   logic [9:0] pin_raw;
   logic [9:0] s1_r;
   logic [9:0] s2_r;
   logic [9:0] s3_r;
   logic [9:0] filt_r;

   assign pin_raw = {hall_in, under_voltage_in, over_voltage_in, overload_in,
                     over_current_in, stop_method_in, run_in, direction_select_in};

   // Three flops; a change counts once second and third agree
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         s1_r <= bdc_pkg::IN_RESET;
         s2_r <= bdc_pkg::IN_RESET;
         s3_r <= bdc_pkg::IN_RESET;
      end else begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Per-bit stability counter; new level accepted after DEB_CYC cycles
   genvar gi;
   generate
      for (gi = 0; gi < bdc_pkg::NIN; gi++) begin : g_deb
         logic [15:0] cnt_r;
         always_ff @(posedge sys_clk_in) begin
            if (reset_in) begin
               cnt_r <= 16'h0000;
               filt_r[gi] <= bdc_pkg::IN_RESET[gi]; // R5
            end else if (s2_r[gi] != s3_r[gi] || s3_r[gi] == filt_r[gi]) begin
               cnt_r <= 16'h0000;
            end else if (cnt_r >= 16'(DEB_CYC - 1)) begin
               cnt_r <= 16'h0000;
               filt_r[gi] <= s3_r[gi]; // R18
            end else begin
               cnt_r <= cnt_r + 16'h0001;
            end
         end
      end
   endgenerate

   logic [2:0] hall_f;
   assign hall_f = filt_r[bdc_pkg::IN_HALL +: 3];

   // ----------------------------------------
   // Alarm detection and latch
   // ----------------------------------------
   logic [2:0] alarm_code_r;
   logic alarm_r;
   logic halt;
   logic [2:0] hall_d_r;
   logic hall_move;
   logic [31:0] start_cnt_r;
   logic start_fail;
   logic hall_bad;
   logic [2:0] cause_code;
   logic [6:0] cause_vec;

   // Halt from run pin or a low setpoint
   assign halt = ~filt_r[bdc_pkg::IN_RUN] // R2
                 | (speed_setpoint_in < bdc_pkg::HALT_CODE); // R9
   assign hall_move = (hall_f != hall_d_r);
   assign hall_bad = (hall_f == 3'h0) || (hall_f == 3'h7); // R13

   // Hall history for edge detection
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         hall_d_r <= bdc_pkg::IN_RESET[bdc_pkg::IN_HALL +: 3];
      end else begin
         hall_d_r <= hall_f;
      end
   end

   // Time since last hall edge while a run is commanded
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || halt || alarm_r || hall_move) begin
         start_cnt_r <= 32'h0000_0000;
      end else if (!start_fail) begin
         start_cnt_r <= start_cnt_r + 32'h0000_0001;
      end
   end
   assign start_fail = (start_cnt_r >= 32'(START_CYC)); // R16

   // Active causes, one bit per alarm code
   assign cause_vec = {start_fail, 1'b0, filt_r[bdc_pkg::IN_UV],
                       filt_r[bdc_pkg::IN_OV], hall_bad,
                       filt_r[bdc_pkg::IN_OL], filt_r[bdc_pkg::IN_OC]};

   // Lowest code wins when causes coincide
   always_comb begin
      cause_code = bdc_pkg::ALM_NONE;
      if (cause_vec[0]) begin
         cause_code = bdc_pkg::ALM_OC; // R12
      end else if (cause_vec[1]) begin
         cause_code = bdc_pkg::ALM_OL; // R12
      end else if (cause_vec[2]) begin
         cause_code = bdc_pkg::ALM_HALL; // R13
      end else if (cause_vec[3]) begin
         cause_code = bdc_pkg::ALM_OV; // R14
      end else if (cause_vec[4]) begin
         cause_code = bdc_pkg::ALM_UV; // R15
      end else if (cause_vec[6]) begin
         cause_code = bdc_pkg::ALM_START; // R16
      end
   end

   // First alarm latched until reset
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         alarm_r <= 1'b0;
         alarm_code_r <= bdc_pkg::ALM_NONE;
      end else if (!alarm_r && cause_code != bdc_pkg::ALM_NONE) begin
         alarm_r <= 1'b1; // R11
         alarm_code_r <= cause_code; // R17
      end
   end

   // ----------------------------------------
   // Drive commands
   // ----------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         motor_enable_out <= 1'b0;
         direction_out <= 1'b1;
         brake_out <= 1'b0;
         target_speed_out <= 10'h000;
      end else if (alarm_r) begin
         motor_enable_out <= 1'b0; // R10
         brake_out <= 1'b0; // R10
         target_speed_out <= 10'h000; // R11
      end else begin
         motor_enable_out <= ~halt; // R2
         direction_out <= filt_r[bdc_pkg::IN_DIR]; // R1
         brake_out <= halt & ~filt_r[bdc_pkg::IN_STOPM]; // R3
         target_speed_out <= halt ? 10'h000 : speed_setpoint_in; // R8
      end
   end

   // Fault output and power lamp
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         fault_output_out <= 1'b0;
         power_indicator_led_out <= 1'b0;
      end else begin
         fault_output_out <= alarm_r; // R6
         power_indicator_led_out <= 1'b1;
      end
   end

   // Speed pulse toggles at every hall edge until an alarm latches, then holds
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         speed_pulse_output_out <= 1'b0;
      end else if (hall_move && !alarm_r) begin
         speed_pulse_output_out <= ~speed_pulse_output_out; // R7
      end
   end

   // ----------------------------------------
   // Fault lamp blink sequencer
   // ----------------------------------------
   bdc_pkg::bdc_blink_t bl_state_r;
   logic [31:0] bl_tmr_r;
   logic [2:0] bl_cnt_r;

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         bl_state_r <= bdc_pkg::BL_IDLE;
         bl_tmr_r <= 32'h0000_0000;
         bl_cnt_r <= 3'h0;
      end else begin
         unique case (bl_state_r)
            bdc_pkg::BL_IDLE: begin
               bl_tmr_r <= 32'h0000_0000;
               bl_cnt_r <= 3'h0;
               if (alarm_r) begin
                  bl_state_r <= bdc_pkg::BL_ON; // R10
               end
            end
            bdc_pkg::BL_ON: begin
               if (bl_tmr_r >= 32'(ON_CYC - 1)) begin
                  bl_tmr_r <= 32'h0000_0000;
                  bl_cnt_r <= bl_cnt_r + 3'h1;
                  bl_state_r <= bdc_pkg::BL_OFF;
               end else begin
                  bl_tmr_r <= bl_tmr_r + 32'h0000_0001;
               end
            end
            bdc_pkg::BL_OFF: begin
               if (bl_tmr_r >= 32'(OFF_CYC - 1)) begin
                  bl_tmr_r <= 32'h0000_0000;
                  if (bl_cnt_r == alarm_code_r) begin
                     bl_state_r <= bdc_pkg::BL_GAP; // R12
                  end else begin
                     bl_state_r <= bdc_pkg::BL_ON;
                  end
               end else begin
                  bl_tmr_r <= bl_tmr_r + 32'h0000_0001;
               end
            end
            bdc_pkg::BL_GAP: begin
               if (bl_tmr_r >= 32'(GAP_CYC - 1)) begin
                  bl_tmr_r <= 32'h0000_0000;
                  bl_cnt_r <= 3'h0;
                  bl_state_r <= bdc_pkg::BL_ON; // R17
               end else begin
                  bl_tmr_r <= bl_tmr_r + 32'h0000_0001;
               end
            end
         endcase
      end
   end

   // Lamp lit only in the on phase
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         fault_indicator_led_out <= 1'b0;
      end else begin
         fault_indicator_led_out <= (bl_state_r == bdc_pkg::BL_ON);
      end
   end

   // ----------------------------------------
   // Register port and interrupt
   // ----------------------------------------
   logic [6:0] status_r;
   logic [6:0] mask_r;
   logic [6:0] status_nxt;
   logic stat_rd;
   logic [6:0] alm_event;

   assign stat_rd = reg_rd_in && (reg_addr_in == bdc_pkg::REG_STATUS);

   // Event set when the latch takes an alarm
   always_comb begin
      alm_event = 7'h00;
      if (!alarm_r && cause_code != bdc_pkg::ALM_NONE) begin
         alm_event[cause_code - 3'h1] = 1'b1;
      end
   end

   // Read clears, a new event in the same cycle wins
   assign status_nxt = (stat_rd ? 7'h00 : status_r) | alm_event;

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         status_r <= 7'h00;
      end else begin
         status_r <= status_nxt;
      end
   end

   // Mask register write
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         mask_r <= bdc_pkg::MASK_RESET;
      end else if (reg_wr_in && reg_addr_in == bdc_pkg::REG_MASK) begin
         mask_r <= reg_wdata_in[6:0];
      end
   end

   // Read data in the cycle after the strobe only
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || !reg_rd_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else begin
         unique case (reg_addr_in)
            bdc_pkg::REG_STATUS: reg_rdata_out <= {25'h0, status_r};
            bdc_pkg::REG_MASK: reg_rdata_out <= {25'h0, mask_r};
            bdc_pkg::REG_ALARM: reg_rdata_out <= {28'h0, alarm_r, alarm_code_r};
            bdc_pkg::REG_STATE: reg_rdata_out <= {24'h0, hall_f, speed_pulse_output_out,
                                                  brake_out, direction_out,
                                                  motor_enable_out, halt};
            default: reg_rdata_out <= 32'h0000_0000;
         endcase
      end
   end

   // Level interrupt from unmasked sticky bits
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(status_nxt & mask_r);
      end
   end
endmodule : bdc_drive_ctrl
`default_nettype wire

// ===== design/bdc_pkg.sv
// ----------------------------------------
// Shared constants of the drive control
// ----------------------------------------
package bdc_pkg;
   // Clock rate
   localparam int CLK_HZ = 20_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int CYC_PER_US = CLK_HZ / 1_000_000;

   // Input filter and timing, in their own units
   localparam int DEBOUNCE_US = 100;
   localparam int BLINK_ON_MS = 250;
   localparam int BLINK_OFF_MS = 250;
   localparam int GROUP_PAUSE_MS = 1500;
   localparam int STARTUP_MS = 1000;

   // Derived cycle counts
   localparam int DEBOUNCE_CYC = DEBOUNCE_US * CYC_PER_US;
   localparam int BLINK_ON_CYC = BLINK_ON_MS * CYC_PER_MS;
   localparam int BLINK_OFF_CYC = BLINK_OFF_MS * CYC_PER_MS;
   localparam int GROUP_PAUSE_CYC = GROUP_PAUSE_MS * CYC_PER_MS;
   localparam int STARTUP_CYC = STARTUP_MS * CYC_PER_MS;

   // Speed setpoint conversion and halt threshold
   localparam int SETPT_W = 10;
   localparam int ADC_FULL_MV = 5000;
   localparam int HALT_MV = 500;
   localparam logic [9:0] HALT_CODE =
      10'((HALT_MV * 1024 + ADC_FULL_MV - 1) / ADC_FULL_MV);

   // Filtered input vector layout
   localparam int NIN = 10;
   localparam int IN_DIR = 0;
   localparam int IN_RUN = 1;
   localparam int IN_STOPM = 2;
   localparam int IN_OC = 3;
   localparam int IN_OL = 4;
   localparam int IN_OV = 5;
   localparam int IN_UV = 6;
   localparam int IN_HALL = 7;
   localparam logic [9:0] IN_RESET = 10'h087;

   // Alarm codes, equal to the blink count
   localparam logic [2:0] ALM_NONE = 3'h0;
   localparam logic [2:0] ALM_OC = 3'h1;
   localparam logic [2:0] ALM_OL = 3'h2;
   localparam logic [2:0] ALM_HALL = 3'h3;
   localparam logic [2:0] ALM_OV = 3'h4;
   localparam logic [2:0] ALM_UV = 3'h5;
   localparam logic [2:0] ALM_START = 3'h7;

   // Register offsets
   localparam int AW = 4;
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MASK = 4'h4;
   localparam logic [3:0] REG_ALARM = 4'h8;
   localparam logic [3:0] REG_STATE = 4'hC;
   localparam logic [6:0] MASK_RESET = 7'h00;

   // Blink sequencer states
   typedef enum logic [1:0] {
      BL_IDLE = 2'b00,
      BL_ON = 2'b01,
      BL_OFF = 2'b10,
      BL_GAP = 2'b11
   } bdc_blink_t;
endpackage : bdc_pkg

// ===== bench/bdc_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Controller and hall sensor model
// ------
module bdc_ctl_model (
   // Clock
   input wire logic sys_clk_in,
   // Bench commands
   input wire logic dir_cmd_in,
   input wire logic run_cmd_in,
   input wire logic stopm_cmd_in,
   input wire logic spin_in,
   input wire logic hall_bad_in,
   // Connector and sensor pins
   output logic direction_select_out = 1'b1,
   output logic run_out = 1'b1,
   output logic stop_method_out = 1'b1,
   output logic [2:0] hall_out
);
   localparam logic [2:0] SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
   logic [7:0] run_dly_r = 8'hFF;
   logic [5:0] pos_r = 6'h00;
   // Stop method settles well before the run level follows
   always @(posedge sys_clk_in) begin
      direction_select_out <= dir_cmd_in;
      stop_method_out <= stopm_cmd_in;
      run_dly_r <= {run_dly_r[6:0], run_cmd_in};
      run_out <= run_dly_r[7];
   end
   // Hall position steps every ten cycles while the shaft turns
   always @(posedge sys_clk_in) begin
      if (spin_in) begin
         pos_r <= (pos_r == 6'h3B) ? 6'h00 : pos_r + 6'h01;
      end
   end
   // A broken sensor reads all low
   assign hall_out = hall_bad_in ? 3'h0 : SEQ[pos_r / 6'h0A];
endmodule : bdc_ctl_model
`default_nettype wire

// ===== bench/bdc_drive_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Port checker
// ------
module bdc_drive_ctrl_props (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Watched inputs
   input wire logic [9:0] speed_setpoint_in,
   input wire logic reg_rd_in,
   // Watched outputs
   input wire logic [31:0] reg_rdata_out,
   input wire logic motor_enable_out,
   input wire logic direction_out,
   input wire logic brake_out,
   input wire logic [9:0] target_speed_out,
   input wire logic fault_output_out,
   input wire logic speed_pulse_output_out,
   input wire logic fault_indicator_led_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (reset_in);
   // Alarm handling
   a_alarm_cuts_drive: assert property (fault_output_out |-> !motor_enable_out && !brake_out)
      else $error("drive on in alarm");
   a_alarm_stays: assert property (fault_output_out |=> fault_output_out)
      else $error("alarm cleared");
   a_dir_frozen: assert property ($past(fault_output_out) |-> $stable(direction_out))
      else $error("direction moved in alarm");
   a_pulse_frozen: assert property ($past(fault_output_out) |-> $stable(speed_pulse_output_out))
      else $error("speed pulse moved in alarm");
   a_led_needs_alarm: assert property (fault_indicator_led_out |-> fault_output_out)
      else $error("led lit without alarm");
   // Drive commands and read data
   a_low_setpt_halt: assert property ((speed_setpoint_in < bdc_pkg::HALT_CODE) [*4] |-> !motor_enable_out)
      else $error("low setpoint not halted");
   a_brake_idle: assert property (motor_enable_out |-> !brake_out)
      else $error("brake while driving");
   a_speed_needs_run: assert property (target_speed_out != 10'h000 |-> motor_enable_out)
      else $error("speed without drive");
   a_read_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
      else $error("read data without read");
   // Main scenarios reached
   c_alarm: cover property ($rose(fault_output_out));
   c_brake: cover property (brake_out);
   c_blink: cover property ($rose(fault_indicator_led_out));
endmodule : bdc_drive_ctrl_props
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
bind bdc_drive_ctrl bdc_drive_ctrl_props i_bdc_drive_ctrl_props (.sys_clk_in, .reset_in,
   .speed_setpoint_in, .reg_rd_in, .reg_rdata_out, .motor_enable_out, .direction_out, .brake_out,
   .target_speed_out, .fault_output_out, .speed_pulse_output_out, .fault_indicator_led_out);
module tb;
   // ------
   // Signals
   // ------
   logic sys_clk_in, reset_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic over_current_in = 1'b0, overload_in = 1'b0, over_voltage_in = 1'b0;
   logic under_voltage_in = 1'b0, dir_cmd = 1'b1, run_cmd = 1'b1, stopm_cmd = 1'b1;
   logic spin = 1'b0, hall_bad = 1'b0, h;
   logic [9:0] speed_setpoint_in = 10'h000, s;
   logic [3:0] reg_addr_in = 4'h0;
   logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, d;
   logic [2:0] c, hall_in;
   logic [6:0] m;
   logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
   logic direction_select_in, run_in, stop_method_in, irq_out, motor_enable_out, direction_out;
   logic brake_out, fault_output_out, speed_pulse_output_out, fault_indicator_led_out;
   logic power_indicator_led_out;
   logic [9:0] target_speed_out;
   int error_cnt = 0, num_checks = 0, seed = 78825, n, lo, st;
   // Far side and design
   bdc_ctl_model i_bdc_ctl_model (.sys_clk_in, .dir_cmd_in(dir_cmd), .run_cmd_in(run_cmd),
      .stopm_cmd_in(stopm_cmd), .spin_in(spin), .hall_bad_in(hall_bad),
      .direction_select_out(direction_select_in), .run_out(run_in),
      .stop_method_out(stop_method_in), .hall_out(hall_in));
   bdc_drive_ctrl #(.DEB_CYC(4), .ON_CYC(5), .OFF_CYC(5), .GAP_CYC(20), .START_CYC(200))
   i_bdc_drive_ctrl (.sys_clk_in, .reset_in, .direction_select_in, .run_in, .stop_method_in,
      .speed_setpoint_in, .over_current_in, .overload_in, .over_voltage_in, .under_voltage_in,
      .hall_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out,
      .motor_enable_out, .direction_out, .brake_out, .target_speed_out, .fault_output_out,
      .speed_pulse_output_out, .fault_indicator_led_out, .power_indicator_led_out);
   // ------
   // Helpers
   // ------
   task automatic wait_cyc(input int k);
      repeat (k) @(posedge sys_clk_in);
   endtask : wait_cyc
   task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_wr_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask : reg_write
   task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b0;
      @(negedge sys_clk_in);
      v = reg_rdata_out;
      @(posedge sys_clk_in);
   endtask : reg_read
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_word
   task automatic check_pin(input logic got, input logic exp);
      check_word({31'h0, got}, {31'h0, exp});
   endtask : check_pin
   function automatic logic halted(input logic r, input logic [9:0] v);
      return !r || (v < bdc_pkg::HALT_CODE);
   endfunction : halted
   task automatic do_reset();
      reset_in <= 1'b1;
      over_current_in <= 1'b0;
      overload_in <= 1'b0;
      over_voltage_in <= 1'b0;
      under_voltage_in <= 1'b0;
      hall_bad <= 1'b0;
      wait_cyc(6);
      reset_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask : do_reset
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test
   // ------
   // Clock, watchdog and tests
   // ------
   initial begin
      sys_clk_in = 1'b0;
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   // Cuts a hung run short
   initial begin
      #2_000_000;
      error_cnt++;
      end_of_test();
   end
   // Main sequence
   initial begin
      do_reset();
      wait_cyc(2);
      check_pin(power_indicator_led_out, 1'b1);
      check_pin(fault_output_out, 1'b0);
      check_pin(direction_out, 1'b1);
      reg_read(bdc_pkg::REG_MASK, d);
      check_word(d, 32'h0);
      reg_read(4'h2, d);
      check_word(d, 32'h0);
      // Only the mask takes writes; the alarm word stays clear
      reg_write(bdc_pkg::REG_ALARM, 32'h0000_000F);
      reg_read(bdc_pkg::REG_ALARM, d);
      check_word(d, 32'h0);
      // All control levels, then both sides of the halt threshold
      spin <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         s = (i == 8) ? 10'h066 : 10'h067 + 10'((i == 9) ? 0 : $unsigned($random(seed)) % 921);
         dir_cmd <= i[0];
         stopm_cmd <= i[1];
         run_cmd <= i[2] | i[3];
         speed_setpoint_in <= s;
         wait_cyc(30);
         h = halted(i[2] | i[3], s);
         check_pin(motor_enable_out, !h);
         check_pin(direction_out, i[0]);
         check_pin(brake_out, h && !i[1]);
         check_word({22'h0, target_speed_out}, h ? 32'h0 : {22'h0, s});
         reg_read(bdc_pkg::REG_STATE, d);
         check_word(d & 32'h0000_000F, {28'h0, h && !i[1], i[0], !h, h});
      end
      // One electrical turn gives three pulse periods
      n = 0;
      h = speed_pulse_output_out;
      repeat (60) begin
         @(negedge sys_clk_in);
         n += (speed_pulse_output_out !== h);
         h = speed_pulse_output_out;
      end
      check_word(n, 6);
      @(posedge sys_clk_in);
      // A fault pulse shorter than the filter is not taken
      over_current_in <= 1'b1;
      wait_cyc(3);
      over_current_in <= 1'b0;
      wait_cyc(12);
      check_pin(fault_output_out, 1'b0);
      check_pin(motor_enable_out, 1'b1);
      // Each alarm cause from a fresh power-up
      for (int i = 0; i < 6; i++) begin
         c = codes[i];
         do_reset();
         m = 7'($random(seed));
         m[c - 1] = i[0];
         reg_write(bdc_pkg::REG_MASK, {25'h0, m});
         spin <= (c != bdc_pkg::ALM_START);
         run_cmd <= 1'b1;
         stopm_cmd <= 1'b0;
         speed_setpoint_in <= 10'h200;
         wait_cyc(40);
         check_pin(motor_enable_out, 1'b1);
         over_current_in <= (c == bdc_pkg::ALM_OC);
         overload_in <= (c == bdc_pkg::ALM_OL);
         hall_bad <= (c == bdc_pkg::ALM_HALL);
         over_voltage_in <= (c == bdc_pkg::ALM_OV);
         under_voltage_in <= (c == bdc_pkg::ALM_UV);
         wait_cyc(260);
         check_pin(fault_output_out, 1'b1);
         check_pin(motor_enable_out, 1'b0);
         check_pin(irq_out, m[c - 1]);
         // Later causes and control changes leave the first alarm in place
         over_current_in <= 1'b1;
         run_cmd <= 1'b0;
         wait_cyc(30);
         check_pin(fault_output_out, 1'b1);
         check_pin(brake_out, 1'b0);
         reg_read(bdc_pkg::REG_ALARM, d);
         check_word(d, {28'h0, 1'b1, c});
         reg_read(bdc_pkg::REG_STATUS, d);
         check_word(d, 32'h1 << (c - 1));
         reg_read(bdc_pkg::REG_STATUS, d);
         check_word(d, 32'h0);
         check_pin(irq_out, 1'b0);
         // Count the blinks of one group framed by long pauses
         lo = 0;
         n = 0;
         st = 0;
         repeat (400) begin
            @(negedge sys_clk_in);
            if (fault_indicator_led_out !== 1'b1) begin
               lo++;
               st = (lo > 12 && st == 1) ? 2 : st;
            end else begin
               st = (lo > 12 && st == 0) ? 1 : st;
               n += (lo != 0 && st == 1);
               lo = 0;
            end
         end
         check_word(n, {29'h0, c});
         @(posedge sys_clk_in);
      end
      end_of_test();
   end
endmodule : tb
`default_nettype wire
